// ===== mcu_model.sv
// Microcontroller model: serial master for register frames.
// Assumes i_clk is the system clock; frames are called from tb.
`timescale 1ns/1ps
module mcu_model (
   input  wire logic i_clk,
   output logic      o_cs_n,
   output logic      o_sck,
   output logic      o_sdi,
   input  wire logic i_sdo
);
   // *****
   // Idle: select high so status keeps refreshing
   // *****
   initial begin
      o_cs_n = 1'b1;
      o_sck  = 1'b0;
      o_sdi  = 1'b0;
   end
   // One 16-bit frame, MSB first, half period 8 cycles for margin
   task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
      rx = 8'h00;
      @(posedge i_clk) o_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         o_sdi <= tx[i];
         repeat (8) @(posedge i_clk);
         o_sck <= 1'b1;
         if (i < 8) rx = {rx[6:0], i_sdo};
         repeat (8) @(posedge i_clk);
         o_sck <= 1'b0;
      end
      repeat (8) @(posedge i_clk);
      o_sdi  <= ~o_sdi; // Released line must not look held
      o_cs_n <= 1'b1; // Select high commits writes
      repeat (8) @(posedge i_clk);
   endtask
endmodule

// ===== pin_filter.sv
// Three-stage pin synchroniser with agreement filter, one per bit.
// Assumes inputs are asynchronous to i_clk.
`timescale 1ns/1ps
module pin_filter #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_pin,
   output logic      [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   // ************************************************************
   // Per-bit chain; output moves only when stages two and three agree
   // ************************************************************
   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge i_clk) begin
         s1[b] <= i_pin[b];
         s2[b] <= s1[b];
         s3[b] <= s2[b];
         if (i_rst) begin
            o_level[b] <= 1'b0;
         end else if (s2[b] == s3[b]) begin
            o_level[b] <= s3[b];
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_filter_agree_only: assert property ($changed(o_level) |->
      $past((s2 ^ s3) & (o_level ^ s3)) == '0)
      else $error("filter output moved without agreement");
endmodule

// ===== status_predriver_regs.sv
// Serial-access status and gate predriver register bank.
// Assumes pins arrive asynchronously; fault events, microstep index
// come from logic on i_clk.
`timescale 1ns/1ps
module status_predriver_regs #(
   parameter int WDT_STEP_CYCLES   = stepper_regs_pkg::WDT_STEP_CYCLES,
   parameter int WDOG_PULSE_CYCLES = stepper_regs_pkg::WDOG_PULSE_CYCLES
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_chip_select_n,
   input  wire logic       i_spi_clk,
   input  wire logic       i_spi_data_in,
   output logic            o_spi_data_out,
   input  wire logic [1:0] i_thermal_band,
   input  wire logic       i_thermal_shutdown_flag,
   input  wire logic [7:0] i_microstep_index,
   input  wire logic [7:0] i_fault_events,
   output logic            o_watchdog_reset_oe,
   output logic            o_thermal_warning,
   output logic            o_thermal_shutdown,
   output logic [6:0]      o_top_charge_current_first,
   output logic [3:0]      o_top_turnoff_current,
   output logic [3:0]      o_bottom_turnoff_current,
   output logic [2:0]      o_top_switch_on_second,
   output logic [2:0]      o_bottom_switch_on_second,
   output logic [2:0]      o_top_switch_on_first,
   output logic [2:0]      o_bottom_switch_on_first
);
   // ************************************************************
   // Pin synchronisation
   // ************************************************************
   logic [5:0] pins_f;
   logic       sclk_prev;
   logic       cs_prev;

   pin_filter #(
      .WIDTH (6)
   ) u_pins (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_pin   ({~i_chip_select_n, i_spi_clk, i_spi_data_in,
                 i_thermal_band, i_thermal_shutdown_flag}),
      .o_level (pins_f)
   );

   wire       cs_n_f = ~pins_f[5]; // Filter resets to 0, read as deselected
   wire       sclk_f = pins_f[4];
   wire       di_f   = pins_f[3];
   wire [1:0] band_f = pins_f[2:1];
   wire       tsd_f  = pins_f[0];

   // Edge events of the filtered serial pins
   wire sclk_rise = !cs_n_f && sclk_f && !sclk_prev;
   wire sclk_fall = !cs_n_f && !sclk_f && sclk_prev;
   wire cs_rise   = cs_n_f && !cs_prev;

   always_ff @(posedge i_clk) begin
      sclk_prev <= i_rst ? 1'b0 : sclk_f;
      cs_prev   <= i_rst ? 1'b1 : cs_n_f;
   end

   // ************************************************************
   // Serial frame: command byte {write, addr[6:0]}, then data byte
   // ************************************************************
   logic [3:0] bit_cnt;
   logic [7:0] shift_in;
   logic [7:0] cmd;
   logic [7:0] tx;

   wire [7:0] next_shift = {shift_in[6:0], di_f};
   wire       cmd_done   = sclk_rise && (bit_cnt == stepper_regs_pkg::CMD_LAST_BIT);
   wire       data_done  = sclk_rise && (bit_cnt == stepper_regs_pkg::FRAME_LAST_BIT);
   wire       frame_new  = sclk_rise && (bit_cnt == 4'h0);
   wire       is_write   = cmd[stepper_regs_pkg::CMD_WRITE];

   // Bit counter wraps every 16 edges so reads may follow back to back
   always_ff @(posedge i_clk) begin
      if (i_rst || cs_n_f) begin
         bit_cnt  <= 4'h0;
         shift_in <= 8'h00;
      end else if (sclk_rise) begin
         bit_cnt  <= bit_cnt + 4'h1;
         shift_in <= next_shift;
      end
   end

   // Command byte is kept for the rest of the frame
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cmd <= 8'h00;
      end else if (cmd_done) begin
         cmd <= next_shift;
      end
   end

   // ************************************************************
   // Deferred write: committed only when select returns high
   // ************************************************************
   logic       wr_pend;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;

   // A new frame before select rises discards the pending write
   always_ff @(posedge i_clk) begin
      if (i_rst || cs_rise || frame_new) begin
         wr_pend <= 1'b0;
      end else if (data_done && is_write) begin
         wr_pend <= 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_addr <= 7'h00;
         wr_data <= 8'h00;
      end else if (data_done && is_write) begin
         wr_addr <= cmd[6:0];
         wr_data <= next_shift;
      end
   end

   wire commit = cs_rise && wr_pend;
   wire wr_wdog = commit && (wr_addr == stepper_regs_pkg::ADDR_WDOG_CTRL);
   wire wr_chg  = commit && (wr_addr == stepper_regs_pkg::ADDR_CHARGE_TOP1);
   wire wr_dis  = commit && (wr_addr == stepper_regs_pkg::ADDR_DISCHARGE);
   wire wr_on2  = commit && (wr_addr == stepper_regs_pkg::ADDR_ON_SECOND);
   wire wr_on1  = commit && (wr_addr == stepper_regs_pkg::ADDR_ON_FIRST);

   // ************************************************************
   // Writable registers
   // ************************************************************
   logic [7:0] wdog_ctrl;
   logic [7:0] gate_charge_source_top_first;
   logic [7:0] gate_discharge_sources;
   logic [7:0] switch_on_time_second;
   logic [7:0] switch_on_time_first;
   logic       wd_fired;

   // Reserved bits are masked on write so they always read zero
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         gate_charge_source_top_first <= stepper_regs_pkg::RST_CHARGE_TOP1;
         gate_discharge_sources       <= stepper_regs_pkg::RST_DISCHARGE;
         switch_on_time_second        <= stepper_regs_pkg::RST_ON_SECOND;
         switch_on_time_first         <= stepper_regs_pkg::RST_ON_FIRST;
      end else begin
         if (wr_chg) begin
            gate_charge_source_top_first <=
               wr_data & stepper_regs_pkg::MASK_CHARGE;
         end
         if (wr_dis) begin
            gate_discharge_sources <=
               wr_data & stepper_regs_pkg::MASK_DISCHARGE;
         end
         if (wr_on2) begin
            switch_on_time_second <=
               wr_data & stepper_regs_pkg::MASK_ON_TIME;
         end
         if (wr_on1) begin
            switch_on_time_first <=
               wr_data & stepper_regs_pkg::MASK_ON_TIME;
         end
      end
   end

   // Watchdog control; a firing disarms it until software rewrites it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wdog_ctrl <= stepper_regs_pkg::RST_WDOG_CTRL;
      end else if (wr_wdog) begin
         wdog_ctrl <= wr_data & stepper_regs_pkg::MASK_WDOG_CTRL;
      end else if (wd_fired) begin
         wdog_ctrl[stepper_regs_pkg::WATCHDOG_ENABLE_BIT] <= 1'b0;
      end
   end

   // Predriver fields straight from the register flops
   assign o_top_charge_current_first =
      {gate_charge_source_top_first[7:4],
       gate_charge_source_top_first[2:0]};
   assign o_top_turnoff_current     = gate_discharge_sources[7:4];
   assign o_bottom_turnoff_current  = gate_discharge_sources[3:0];
   assign o_top_switch_on_second    = switch_on_time_second[6:4];
   assign o_bottom_switch_on_second = switch_on_time_second[2:0];
   assign o_top_switch_on_first     = switch_on_time_first[6:4];
   assign o_bottom_switch_on_first  = switch_on_time_first[2:0];

   // ************************************************************
   // Watchdog
   // ************************************************************
   logic watchdog_event_flag;
   // Writing enable=1 is the acknowledge that restarts the timeout
   wire  wd_kick = wr_wdog && wr_data[stepper_regs_pkg::WATCHDOG_ENABLE_BIT];

   watchdog_timer #(
      .STEP_CYCLES  (WDT_STEP_CYCLES),
      .PULSE_CYCLES (WDOG_PULSE_CYCLES)
   ) u_wdog (
      .i_clk         (i_clk),
      .i_rst         (i_rst),
      .i_enable      (wdog_ctrl[stepper_regs_pkg::WATCHDOG_ENABLE_BIT]),
      .i_kick        (wd_kick),
      .i_timeout_sel (wdog_ctrl[stepper_regs_pkg::WDT_LSB +: 4]),
      .o_fired       (wd_fired),
      .o_reset_oe    (o_watchdog_reset_oe)
   );

   // Cleared only by the device reset: tells warm from cold boot
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         watchdog_event_flag <= 1'b0;
      end else if (wd_fired) begin
         watchdog_event_flag <= 1'b1;
      end
   end

   // ************************************************************
   // Latched faults: sticky, cleared after a frame that reads the fault status ends
   // ************************************************************
   logic [7:0] fault_latch;
   logic [7:0] fault_seen;

   // New events win over the clear in the same cycle
   wire [7:0] fault_clr   = cs_rise ? fault_seen : 8'h00;
   wire [7:0] next_faults = (fault_latch & ~fault_clr) | i_fault_events;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         fault_latch <= stepper_regs_pkg::RST_FAULTS;
      end else begin
         fault_latch <= next_faults;
      end
   end

   // ************************************************************
   // Status snapshots, refreshed only while select is high
   // ************************************************************
   logic [1:0] snap_band;
   logic       snap_tsd;
   logic       snap_wd;
   logic [7:0] snap_mstep;
   logic [7:0] snap_faults;

   // Frozen during a select-low burst so a frame reads one coherent view
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         snap_band   <= 2'b00;
         snap_tsd    <= 1'b0;
         snap_wd     <= 1'b0;
         snap_mstep  <= stepper_regs_pkg::RST_MSTEP;
         snap_faults <= stepper_regs_pkg::RST_FAULTS;
      end else if (cs_n_f) begin
         snap_band   <= band_f;
         snap_tsd    <= tsd_f;
         snap_wd     <= watchdog_event_flag;
         snap_mstep  <= i_microstep_index;
         snap_faults <= fault_latch;
      end
   end

   // Remember which fault bits software actually saw
   always_ff @(posedge i_clk) begin
      if (i_rst || cs_rise) begin
         fault_seen <= 8'h00;
      end else if (cmd_done && !next_shift[stepper_regs_pkg::CMD_WRITE]
                   && next_shift[6:0] == stepper_regs_pkg::ADDR_STAT_FAULT) begin
         fault_seen <= fault_seen | snap_faults;
      end
   end

   // Thermal band in bits 6:5, event flag in bit 4, even parity in bit 7
   wire [6:0] sr0_low = {snap_band, snap_wd, 4'h0};
   wire [7:0] status_thermal_watchdog = {^sr0_low, sr0_low};

   // ************************************************************
   // Read data select; unmapped addresses read zero
   // ************************************************************
   wire [6:0] rd_addr = next_shift[6:0];
   wire [7:0] rd_data =
      (rd_addr == stepper_regs_pkg::ADDR_WDOG_CTRL)   ? wdog_ctrl :
      (rd_addr == stepper_regs_pkg::ADDR_STAT_THERM)  ? status_thermal_watchdog :
      (rd_addr == stepper_regs_pkg::ADDR_STAT_FAULT)  ? snap_faults :
      (rd_addr == stepper_regs_pkg::ADDR_STAT_MSTEP)  ? snap_mstep :
      (rd_addr == stepper_regs_pkg::ADDR_CHARGE_TOP1) ? gate_charge_source_top_first :
      (rd_addr == stepper_regs_pkg::ADDR_DISCHARGE)   ? gate_discharge_sources :
      (rd_addr == stepper_regs_pkg::ADDR_ON_SECOND)   ? switch_on_time_second :
      (rd_addr == stepper_regs_pkg::ADDR_ON_FIRST)    ? switch_on_time_first :
      8'h00;

   // Data leaves MSB first, changing on falling clock edges
   always_ff @(posedge i_clk) begin
      if (i_rst || cs_n_f) begin
         tx             <= 8'h00;
         o_spi_data_out <= 1'b0;
      end else if (cmd_done) begin
         tx <= next_shift[stepper_regs_pkg::CMD_WRITE] ? 8'h00 : rd_data;
      end else if (sclk_fall) begin
         o_spi_data_out <= tx[7];
         tx             <= {tx[6:0], 1'b0};
      end
   end
   // ************************************************************
   // Thermal decode from the live, filtered comparator levels
   // ************************************************************
   wire band_top = (band_f == stepper_regs_pkg::BAND_TOP);
   // Live levels, so a warning never waits for select to rise
   always_ff @(posedge i_clk) begin
      o_thermal_warning  <= !i_rst && band_top && !tsd_f;
      o_thermal_shutdown <= !i_rst && band_top && tsd_f;
   end
   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_status_parity: assert property (
      cmd_done && rd_addr == stepper_regs_pkg::ADDR_STAT_THERM
      |=> ^tx == 1'b0)
      else $error("thermal status parity wrong");
   a_warning_decode: assert property (
      o_thermal_warning == $past(band_f == 2'b11 && !tsd_f))
      else $error("thermal warning decode wrong");
   a_shutdown_decode: assert property (
      ##1 o_thermal_shutdown == $past(band_f == 2'b11 && tsd_f))
      else $error("thermal shutdown decode wrong");
   a_event_flag_set: assert property (wd_fired |=> watchdog_event_flag)
      else $error("watchdog event flag not set");
   a_event_flag_sticky: assert property (
      watchdog_event_flag |=> watchdog_event_flag[*3])
      else $error("watchdog event flag lost");
   a_status_frozen: assert property (
      !cs_n_f |=> $stable(snap_mstep) && $stable(snap_band))
      else $error("status changed while selected");
   a_mstep_follow: assert property (
      cs_n_f |=> snap_mstep == $past(i_microstep_index))
      else $error("microstep snapshot stale");
   a_fault_hold: assert property (
      !cs_rise |=> (fault_latch & $past(fault_latch)) == $past(fault_latch))
      else $error("fault bit lost before read");
   a_reserved_zero: assert property (
      cmd_done && rd_addr == stepper_regs_pkg::ADDR_ON_FIRST
      && !next_shift[7] |=> tx[7] == 1'b0 && tx[3] == 1'b0)
      else $error("reserved bit read nonzero");
   c_write_commit: cover property (commit);
   c_status_read: cover property (cmd_done && rd_addr == stepper_regs_pkg::ADDR_STAT_THERM);
   c_write_discarded: cover property (wr_pend && frame_new);
   c_fault_cleared: cover property (cs_rise && fault_seen != 8'h00);
endmodule

// ===== stepper_regs_pkg.sv
// Constants for the status and gate predriver register bank.
// Assumes a 250 MHz system clock and the serial register frame.
package stepper_regs_pkg;
   // ************************************************************
   // Register addresses (7-bit frame address)
   // ************************************************************
   localparam logic [6:0] ADDR_WDOG_CTRL   = 7'h00;
   localparam logic [6:0] ADDR_STAT_THERM  = 7'h04;
   localparam logic [6:0] ADDR_STAT_FAULT  = 7'h05;
   localparam logic [6:0] ADDR_STAT_MSTEP  = 7'h07;
   localparam logic [6:0] ADDR_CHARGE_TOP1 = 7'h09;
   localparam logic [6:0] ADDR_DISCHARGE   = 7'h0d;
   localparam logic [6:0] ADDR_ON_SECOND   = 7'h0e;
   localparam logic [6:0] ADDR_ON_FIRST    = 7'h10;
   // ************************************************************
   // Reset values and writable-bit masks
   // ************************************************************
   localparam logic [7:0] RST_WDOG_CTRL   = 8'h04;
   localparam logic [7:0] RST_CHARGE_TOP1 = 8'h53;
   localparam logic [7:0] RST_DISCHARGE   = 8'h44;
   localparam logic [7:0] RST_ON_SECOND   = 8'h44;
   localparam logic [7:0] RST_ON_FIRST    = 8'h22;
   localparam logic [7:0] RST_MSTEP       = 8'h00;
   localparam logic [7:0] RST_FAULTS      = 8'h00;
   localparam logic [7:0] MASK_WDOG_CTRL  = 8'hfe;
   localparam logic [7:0] MASK_CHARGE     = 8'hf7;
   localparam logic [7:0] MASK_DISCHARGE  = 8'hff;
   localparam logic [7:0] MASK_ON_TIME    = 8'h77;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int WATCHDOG_ENABLE_BIT  = 7;
   localparam int WDT_LSB   = 3;
   localparam int CMD_WRITE = 7;
   localparam logic [1:0] BAND_TOP = 2'b11;
   // ************************************************************
   // Serial frame and timing
   // ************************************************************
   localparam logic [3:0] CMD_LAST_BIT   = 4'h7;
   localparam logic [3:0] FRAME_LAST_BIT = 4'hf;
   localparam int CLK_PERIOD_NS  = 4;
   localparam int WDT_STEP_NS    = 32_000_000;
   localparam int WDOG_PULSE_NS  = 100_000_000;
   localparam int WDT_STEP_CYCLES   = WDT_STEP_NS / CLK_PERIOD_NS;
   localparam int WDOG_PULSE_CYCLES = WDOG_PULSE_NS / CLK_PERIOD_NS;
endpackage

// ===== tb.sv
// Self-checking bench for the status and predriver register bank.
// Assumes short watchdog parameters so timeouts fit a short run.
`timescale 1ns/1ps
module tb;
   localparam int PULSE = 10;
   logic       clk = 1'b0, rst = 1'b1, cs_n, sck, sdi, sdo, oe, warn, shut, sd;
   logic [1:0] band = 2'h0;
   logic [7:0] idx = 8'h00, flt = 8'h00, rx;
   logic [6:0] chg;
   logic [2:0] sec, bsec, tfirst, bfirst;
   logic [3:0] toff, boff;
   int         oe_hi = 0;
   int         err_total = 0, n_checks = 0;
   always #2 clk = ~clk;
   status_predriver_regs #(.WDT_STEP_CYCLES(20), .WDOG_PULSE_CYCLES(PULSE))
   status_predriver_regs_inst (.i_clk(clk), .i_rst(rst), .i_chip_select_n(cs_n),
      .i_spi_clk(sck), .i_spi_data_in(sdi), .o_spi_data_out(sdo),
      .i_thermal_band(band), .i_thermal_shutdown_flag(sd), .i_microstep_index(idx),
      .i_fault_events(flt), .o_watchdog_reset_oe(oe), .o_thermal_warning(warn),
      .o_thermal_shutdown(shut), .o_top_charge_current_first(chg),
      .o_top_turnoff_current(toff), .o_bottom_turnoff_current(boff),
      .o_top_switch_on_second(sec), .o_bottom_switch_on_second(bsec),
      .o_top_switch_on_first(tfirst), .o_bottom_switch_on_first(bfirst));
   // Counts reset-pulse cycles so a kicked watchdog can be shown silent
   always @(posedge clk) begin
      if (oe === 1'b1) oe_hi <= oe_hi + 1;
   end
   mcu_model mcu_model_inst (.i_clk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi),
      .i_sdo(sdo));
   // *****
   // Shared tasks
   // *****
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      mcu_model_inst.xfer({1'b0, a, 8'h00}, rx);
      chk($sformatf("reg %h", a), e, rx);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      mcu_model_inst.xfer({1'b1, a, d}, rx);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // *****
   // Scenarios
   // *****
   task automatic t_reset;
      rd(7'h09, 8'h53);
      rd(7'h0d, 8'h44);
      rd(7'h0e, 8'h44);
      rd(7'h10, 8'h22);
      rd(7'h07, 8'h00);
      chk("charge out", 8'h2b, {1'b0, chg});
      chk("first out", 8'h22, {1'b0, tfirst, 1'b0, bfirst});
   endtask
   task automatic t_write;
      wr(7'h09, 8'hff);
      rd(7'h09, 8'hf7);
      wr(7'h0e, 8'hff);
      rd(7'h0e, 8'h77);
      chk("second out", 8'h77, {1'b0, sec, 1'b0, bsec});
      wr(7'h10, 8'hff);
      rd(7'h10, 8'h77);
      chk("first out", 8'h77, {1'b0, tfirst, 1'b0, bfirst});
      wr(7'h0d, 8'ha5);
      rd(7'h0d, 8'ha5);
      chk("turnoff out", 8'ha5, {toff, boff});
      wr(7'h04, 8'hff);
      rd(7'h04, 8'h00);
      rd(7'h7f, 8'h00);
   endtask
   // Every band with shutdown low and high; parity is even over the byte
   task automatic t_thermal;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) {band, sd} <= i[2:0];
         repeat (12) @(posedge clk);
         rd(7'h04, {^band, band, 5'h00});
         chk("warn", {7'h0, band == 2'h3 && !sd}, {7'h0, warn});
         chk("shut", {7'h0, band == 2'h3 && sd}, {7'h0, shut});
      end
   endtask
   task automatic t_status;
      @(posedge clk) {band, sd, idx, flt} <= {3'h0, 8'ha5, 8'h81};
      @(posedge clk) flt <= 8'h00;
      repeat (12) @(posedge clk);
      rd(7'h07, 8'ha5);
      rd(7'h05, 8'h81);
      rd(7'h05, 8'h00);
   endtask
   // Kick inside the longest timeout, then let the shortest one run out
   task automatic t_wdog;
      int n = 0;
      repeat (3) wr(7'h00, 8'hf8);
      chk("kicked pulses", 8'h00, oe_hi[7:0]);
      wr(7'h00, 8'h80);
      while (oe !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (oe === 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk("pulse len", PULSE[7:0], n[7:0]);
      chk("pulse count", PULSE[7:0], oe_hi[7:0]);
      rd(7'h04, 8'h90);
      rd(7'h00, 8'h00);
   endtask
   initial begin
      sd = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      t_reset();
      t_write();
      t_thermal();
      t_status();
      t_wdog();
      report_and_stop();
   end
   initial begin
      #200000;
      err_total++;
      report_and_stop();
   end
endmodule

// ===== watchdog_timer.sv
// Watchdog timeout counter and reset pulse timer.
// Assumes enable and kick come from the register bank on i_clk.
`timescale 1ns/1ps
module watchdog_timer #(
   parameter int STEP_CYCLES  = stepper_regs_pkg::WDT_STEP_CYCLES,
   parameter int PULSE_CYCLES = stepper_regs_pkg::WDOG_PULSE_CYCLES
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_enable,
   input  wire logic       i_kick,
   input  wire logic [3:0] i_timeout_sel,
   output logic            o_fired,
   output logic            o_reset_oe
);
   logic [31:0] step_cnt;
   logic [3:0]  step_num;
   logic [31:0] pulse_cnt;
   logic [31:0] chk_len;
   wire step_wrap = (step_cnt == 32'(STEP_CYCLES - 1));
   wire expire    = i_enable && !o_reset_oe && step_wrap
                    && (step_num == i_timeout_sel);

   // ************************************************************
   // Timeout: (sel+1) steps of STEP_CYCLES, restarted by a kick
   // ************************************************************
   always_ff @(posedge i_clk) begin
      if (i_rst || i_kick || !i_enable || o_reset_oe) begin
         step_cnt <= 32'h0;
         step_num <= 4'h0;
      end else if (step_wrap) begin
         step_cnt <= 32'h0;
         step_num <= step_num + 4'h1;
      end else begin
         step_cnt <= step_cnt + 32'h1;
      end
   end

   // Reset pulse holds the pin low for PULSE_CYCLES
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_fired    <= 1'b0;
         o_reset_oe <= 1'b0;
         pulse_cnt  <= 32'h0;
      end else begin
         o_fired <= expire;
         if (expire) begin
            o_reset_oe <= 1'b1;
            pulse_cnt  <= 32'h0;
         end else if (o_reset_oe) begin
            pulse_cnt  <= pulse_cnt + 32'h1;
            if (pulse_cnt == 32'(PULSE_CYCLES - 1)) begin
               o_reset_oe <= 1'b0;
            end
         end
      end
   end

   // Helper: length of the current low pulse
   always_ff @(posedge i_clk) begin
      chk_len <= (i_rst || !o_reset_oe) ? 32'h0 : chk_len + 32'h1;
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_pulse_length: assert property ($fell(o_reset_oe) |->
      chk_len == 32'(PULSE_CYCLES))
      else $error("watchdog pulse length wrong");
   a_fire_starts_pulse: assert property (o_fired |-> o_reset_oe)
      else $error("fire without reset pulse");
   c_watchdog_fires: cover property (o_fired);
endmodule
